// *** core/lsfw_loop_flags.sv ***
`timescale 1ns/100ps
`include "lsfw_params.svh"

module lsfw_loop_flags #(
	parameter int WORD_W = `LSFW_WORD_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sensor_absent,
	input wire logic sensor_open,
	input wire logic cjc_fault,
	input wire logic wdt_error,
	input wire logic [WORD_W-1:0] pv,
	input wire logic [WORD_W-1:0] range_lo,
	input wire logic [WORD_W-1:0] range_hi,
	input wire logic [WORD_W-1:0] al1_lo,
	input wire logic [WORD_W-1:0] al1_hi,
	input wire logic [WORD_W-1:0] al2_lo,
	input wire logic [WORD_W-1:0] al2_hi,
	input wire logic tuned_update,
	input wire logic pid_sent,
	input wire logic setting_invalid,
	input wire logic control_stopped,
	input wire logic ctrl_out,
	input wire logic autotune_running,
	input wire logic standby,
	input wire logic save_req,
	input wire logic save_done,
	output logic save_start,
	output logic [WORD_W-1:0] status_word
);

	lsfw_pkg::lsfw_loop_state_t s;
	lsfw_pkg::lsfw_loop_state_t next_s;
	logic req_rise;
	logic sensor_err;
	logic in_al1;
	logic in_al2;

	assign req_rise = save_req & ~s.req_seen;
	assign sensor_err = sensor_absent | sensor_open | ($signed(pv) < $signed(range_lo)) |
		($signed(pv) > $signed(range_hi));
	assign in_al1 = ~sensor_err & ($signed(pv) >= $signed(al1_lo)) & ($signed(pv) <= $signed(al1_hi));
	assign in_al2 = ~sensor_err & ($signed(pv) >= $signed(al2_lo)) & ($signed(pv) <= $signed(al2_hi));

	always_comb begin
		next_s = s;
		next_s.start = 1'b0;
		next_s.req_seen = save_req;
		unique case (s.save_state)
			lsfw_pkg::SAVE_IDLE: begin
				if (req_rise) begin
					next_s.save_state = lsfw_pkg::SAVE_BUSY;
					next_s.start = 1'b1;
				end
			end
			lsfw_pkg::SAVE_BUSY: begin
				if (save_done) begin
					next_s.save_state = lsfw_pkg::SAVE_IDLE;
				end
			end
		endcase
		// Completion beats a request edge in the same cycle
		if (req_rise) begin
			next_s.saved = 1'b0;
		end
		if (s.save_state == lsfw_pkg::SAVE_BUSY && save_done) begin
			next_s.saved = 1'b1;
		end
		// Tuned constants stay pending until the host has sent them
		if (pid_sent) begin
			next_s.tuned = 1'b0;
		end
		if (tuned_update) begin
			next_s.tuned = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '{lsfw_pkg::SAVE_IDLE, 1'b0, 1'b0, 1'b0, 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign save_start = s.start;

	always_comb begin
		status_word = `LSFW_RESET_WORD;
		status_word[`LSFW_BIT_SAVED] = s.saved;
		status_word[`LSFW_BIT_SENSOR] = sensor_err;
		status_word[`LSFW_BIT_FATAL] = cjc_fault | wdt_error;
		status_word[`LSFW_BIT_STANDBY] = standby;
		status_word[`LSFW_BIT_TUNED] = s.tuned;
		status_word[`LSFW_BIT_SETERR] = setting_invalid;
		status_word[`LSFW_BIT_STOP] = control_stopped;
		status_word[`LSFW_BIT_CTRLOUT] = ctrl_out;
		status_word[`LSFW_BIT_AT] = autotune_running;
		status_word[`LSFW_BIT_AL1] = in_al1;
		status_word[`LSFW_BIT_AL2] = in_al2;
	end

	sequence q_req_edge;
		save_req && !s.req_seen;
	endsequence

	property p_req_clears;
		@(posedge clk) disable iff (sys_rst)
		q_req_edge and !(s.save_state == lsfw_pkg::SAVE_BUSY && save_done) |=> !s.saved;
	endproperty
	a_req_clears: assert property (p_req_clears) else $error("Save flag not cleared by request");

	property p_done_sets;
		@(posedge clk) disable iff (sys_rst)
		(s.save_state == lsfw_pkg::SAVE_BUSY && save_done) |=> s.saved && status_word[`LSFW_BIT_SAVED];
	endproperty
	a_done_sets: assert property (p_done_sets) else $error("Save flag not set on completion");

	property p_saved_after_reset;
		@(posedge clk) sys_rst |=> !s.saved;
	endproperty
	a_saved_after_reset: assert property (p_saved_after_reset) else $error("Save flag high after reset");

	property p_tuned_set;
		@(posedge clk) disable iff (sys_rst)
		tuned_update |=> status_word[`LSFW_BIT_TUNED];
	endproperty
	a_tuned_set: assert property (p_tuned_set) else $error("Tuned flag not set");

	property p_tuned_clear;
		@(posedge clk) disable iff (sys_rst)
		pid_sent && !tuned_update |=> !s.tuned;
	endproperty
	a_tuned_clear: assert property (p_tuned_clear) else $error("Tuned flag not cleared after send");

endmodule // lsfw_loop_flags

// *** core/lsfw_params.svh ***
`ifndef LSFW_PARAMS_SVH
`define LSFW_PARAMS_SVH

`define LSFW_WORD_W 16
`define LSFW_ADDR_W 4
`define LSFW_OFS_LOOP1 4'h8
`define LSFW_OFS_LOOP2 4'h9

`define LSFW_BIT_SAVED 15
`define LSFW_BIT_SENSOR 14
`define LSFW_BIT_FATAL 12
`define LSFW_BIT_STANDBY 11
`define LSFW_BIT_TUNED 10
`define LSFW_BIT_SETERR 9
`define LSFW_BIT_STOP 8
`define LSFW_BIT_CTRLOUT 4
`define LSFW_BIT_AT 3
`define LSFW_BIT_AL1 1
`define LSFW_BIT_AL2 0
`define LSFW_RESERVED_MASK 16'h20e4

`define LSFW_SAVE_BIT_LOOP1 15
`define LSFW_SAVE_BIT_LOOP2 14

`define LSFW_RESET_WORD 16'h0000
`define LSFW_CLK_HZ 20000000
`define LSFW_WDT_MS 1000
`define LSFW_MS_PER_S 1000

`endif

// *** core/lsfw_pkg.sv ***
`include "lsfw_params.svh"

package lsfw_pkg;

	typedef enum logic [0:0] {
		SAVE_IDLE,
		SAVE_BUSY
	} lsfw_save_t;

	typedef struct packed {
		lsfw_save_t save_state;
		logic saved;
		logic tuned;
		logic req_seen;
		logic start;
	} lsfw_loop_state_t;

	typedef struct packed {
		logic [5:0] sync_a;
		logic [5:0] sync_b;
		logic standby;
		logic wdt_err;
		logic [31:0] wdt_cnt;
		logic [`LSFW_WORD_W-1:0] word1;
		logic [`LSFW_WORD_W-1:0] word2;
		logic [`LSFW_WORD_W-1:0] rd_data;
		logic rd_valid;
	} lsfw_top_state_t;

endpackage

// *** core/lsfw_status_word.sv ***
`timescale 1ns/100ps
`include "lsfw_params.svh"

module lsfw_status_word #(
	parameter int WORD_W = `LSFW_WORD_W,
	parameter int ADDR_W = `LSFW_ADDR_W,
	parameter int unsigned WDT_MS = `LSFW_WDT_MS,
	parameter int unsigned WDT_CYCLES = WDT_MS * (`LSFW_CLK_HZ / `LSFW_MS_PER_S)
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic io_refresh,
	input wire logic unit_restart,
	input wire logic [1:0] sensor_absent,
	input wire logic [1:0] sensor_open,
	input wire logic [1:0] cjc_fault,
	input wire logic [1:0][WORD_W-1:0] pv,
	input wire logic [1:0][WORD_W-1:0] range_lo,
	input wire logic [1:0][WORD_W-1:0] range_hi,
	input wire logic [1:0][WORD_W-1:0] al1_lo,
	input wire logic [1:0][WORD_W-1:0] al1_hi,
	input wire logic [1:0][WORD_W-1:0] al2_lo,
	input wire logic [1:0][WORD_W-1:0] al2_hi,
	input wire logic [1:0] tuned_update,
	input wire logic [1:0] pid_sent,
	input wire logic [1:0] setting_invalid,
	input wire logic [1:0] control_stopped,
	input wire logic [1:0] ctrl_out,
	input wire logic [1:0] autotune_running,
	input wire logic [WORD_W-1:0] save_word,
	input wire logic [1:0] save_done,
	output logic [1:0] save_start,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [WORD_W-1:0] rd_data,
	output logic rd_valid,
	output logic [WORD_W-1:0] loop1_status_word,
	output logic [WORD_W-1:0] loop2_status_word,
	output logic wdt_error
);

	localparam logic [31:0] WDT_LAST = 32'(WDT_CYCLES - 1);

	lsfw_pkg::lsfw_top_state_t s;
	lsfw_pkg::lsfw_top_state_t next_s;
	logic [1:0][WORD_W-1:0] live_word;
	logic [1:0] save_req;
	logic [1:0] absent_q;
	logic [1:0] open_q;
	logic [1:0] cjc_q;

	// Pin inputs after the second synchroniser stage
	assign absent_q = s.sync_b[1:0];
	assign open_q = s.sync_b[3:2];
	assign cjc_q = s.sync_b[5:4];

	// Host save word: bit 15 asks for loop 1, bit 14 for loop 2
	assign save_req[0] = save_word[`LSFW_SAVE_BIT_LOOP1];
	assign save_req[1] = save_word[`LSFW_SAVE_BIT_LOOP2];

	for (genvar g = 0; g < 2; g++) begin : g_loop
		lsfw_loop_flags #(
			.WORD_W(WORD_W)
		) u_flags (
			.clk(clk),
			.sys_rst(sys_rst),
			.sensor_absent(absent_q[g]),
			.sensor_open(open_q[g]),
			.cjc_fault(cjc_q[g]),
			.wdt_error(s.wdt_err),
			.pv(pv[g]),
			.range_lo(range_lo[g]),
			.range_hi(range_hi[g]),
			.al1_lo(al1_lo[g]),
			.al1_hi(al1_hi[g]),
			.al2_lo(al2_lo[g]),
			.al2_hi(al2_hi[g]),
			.tuned_update(tuned_update[g]),
			.pid_sent(pid_sent[g]),
			.setting_invalid(setting_invalid[g]),
			.control_stopped(control_stopped[g]),
			.ctrl_out(ctrl_out[g]),
			.autotune_running(autotune_running[g]),
			.standby(s.standby),
			.save_req(save_req[g]),
			.save_done(save_done[g]),
			.save_start(save_start[g]),
			.status_word(live_word[g])
		);
	end

	always_comb begin
		next_s = s;
		next_s.sync_a = {cjc_fault, sensor_open, sensor_absent};
		next_s.sync_b = s.sync_a;
		next_s.rd_valid = rd_en;
		// Words are snapshots; host reads never alter any flag
		if (io_refresh) begin
			next_s.word1 = live_word[0];
			next_s.word2 = live_word[1];
			next_s.standby = 1'b0;
		end
		// Watchdog only runs once the host has started refreshing
		if (io_refresh || s.standby) begin
			next_s.wdt_cnt = '0;
		end else if (!s.wdt_err) begin
			if (s.wdt_cnt == WDT_LAST) begin
				next_s.wdt_err = 1'b1;
			end else begin
				next_s.wdt_cnt = s.wdt_cnt + 32'h1;
			end
		end
		if (unit_restart) begin
			next_s.standby = 1'b1;
			next_s.wdt_err = 1'b0;
			next_s.wdt_cnt = '0;
		end
		if (rd_en) begin
			unique case (rd_addr)
				`LSFW_OFS_LOOP1: next_s.rd_data = s.word1;
				`LSFW_OFS_LOOP2: next_s.rd_data = s.word2;
				default: next_s.rd_data = `LSFW_RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '{6'h00, 6'h00, 1'b1, 1'b0, 32'h0, `LSFW_RESET_WORD, `LSFW_RESET_WORD,
				`LSFW_RESET_WORD, 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.rd_data;
	assign rd_valid = s.rd_valid;
	assign loop1_status_word = s.word1;
	assign loop2_status_word = s.word2;
	assign wdt_error = s.wdt_err;

	sequence q_sensor_fault(int i);
		absent_q[i] || open_q[i];
	endsequence

	property p_sensor_bit;
		@(posedge clk) disable iff (sys_rst)
		q_sensor_fault(0) |-> live_word[0][`LSFW_BIT_SENSOR];
	endproperty
	a_sensor_bit: assert property (p_sensor_bit) else $error("Sensor fault not flagged");

	property p_sensor_pin_delay;
		@(posedge clk) disable iff (sys_rst)
		sensor_absent[1] ##1 sensor_absent[1] |=> live_word[1][`LSFW_BIT_SENSOR];
	endproperty
	a_sensor_pin_delay: assert property (p_sensor_pin_delay) else $error("Sensor pin not seen two cycles on");

	property p_reserved_zero;
		@(posedge clk) disable iff (sys_rst)
		((loop1_status_word | loop2_status_word | live_word[0] | live_word[1]) & `LSFW_RESERVED_MASK) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved status bit set");

	property p_fatal;
		@(posedge clk) disable iff (sys_rst)
		(s.wdt_err || cjc_q[0]) |-> live_word[0][`LSFW_BIT_FATAL];
	endproperty
	a_fatal: assert property (p_fatal) else $error("Fatal bit missing");

	property p_wdt_fires;
		@(posedge clk) disable iff (sys_rst || unit_restart)
		(s.wdt_cnt == WDT_LAST && !io_refresh && !s.standby && !s.wdt_err) |=> wdt_error;
	endproperty
	a_wdt_fires: assert property (p_wdt_fires) else $error("Watchdog timeout not flagged");

	property p_standby_holds;
		@(posedge clk) disable iff (sys_rst)
		s.standby && !io_refresh |=> s.standby;
	endproperty
	a_standby_holds: assert property (p_standby_holds) else $error("Standby dropped before refresh");

	property p_standby_ends;
		@(posedge clk) disable iff (sys_rst)
		io_refresh && !unit_restart |=> !s.standby ##1 (!s.standby || $past(unit_restart));
	endproperty
	a_standby_ends: assert property (p_standby_ends) else $error("Standby not cleared by refresh");

	property p_live_bits;
		@(posedge clk) disable iff (sys_rst)
		live_word[1][`LSFW_BIT_SETERR] == setting_invalid[1] && live_word[1][`LSFW_BIT_STOP] == control_stopped[1]
		&& live_word[0][`LSFW_BIT_CTRLOUT] == ctrl_out[0] && live_word[0][`LSFW_BIT_AT] == autotune_running[0];
	endproperty
	a_live_bits: assert property (p_live_bits) else $error("Live status bit mismatch");

	property p_alarm;
		@(posedge clk) disable iff (sys_rst)
		!(absent_q[0] || open_q[0]) && $signed(pv[0]) >= $signed(al1_lo[0]) && $signed(pv[0]) <= $signed(al1_hi[0])
		&& $signed(pv[0]) >= $signed(range_lo[0]) && $signed(pv[0]) <= $signed(range_hi[0])
		|-> live_word[0][`LSFW_BIT_AL1];
	endproperty
	a_alarm: assert property (p_alarm) else $error("Alarm one not flagged in range");

	property p_sample;
		@(posedge clk) disable iff (sys_rst)
		io_refresh |=> loop1_status_word == $past(live_word[0]) && loop2_status_word == $past(live_word[1]);
	endproperty
	a_sample: assert property (p_sample) else $error("Refresh did not sample status");

	property p_hold;
		@(posedge clk) disable iff (sys_rst)
		!io_refresh |=> $stable(loop1_status_word) && $stable(loop2_status_word);
	endproperty
	a_hold: assert property (p_hold) else $error("Status word changed between refreshes");

	property p_read;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr == `LSFW_OFS_LOOP2 && !io_refresh |=> rd_valid && rd_data == loop2_status_word;
	endproperty
	a_read: assert property (p_read) else $error("Loop 2 read wrong");

	property p_save_start;
		@(posedge clk) disable iff (sys_rst)
		$rose(save_word[`LSFW_SAVE_BIT_LOOP2]) ##1 save_start[1] |-> ##1 !save_start[1];
	endproperty
	a_save_start: assert property (p_save_start) else $error("Save start not one cycle");

	property p_sensor_bit_two;
		@(posedge clk) disable iff (sys_rst)
		q_sensor_fault(1) |-> live_word[1][`LSFW_BIT_SENSOR];
	endproperty
	a_sensor_bit_two: assert property (p_sensor_bit_two) else $error("Loop 2 sensor fault not flagged");

	property p_sensor_range;
		@(posedge clk) disable iff (sys_rst)
		$signed(pv[1]) > $signed(range_hi[1]) |-> live_word[1][`LSFW_BIT_SENSOR];
	endproperty
	a_sensor_range: assert property (p_sensor_range) else $error("Out of range input not flagged");

	property p_fatal_two;
		@(posedge clk) disable iff (sys_rst)
		(s.wdt_err || cjc_q[1]) |-> live_word[1][`LSFW_BIT_FATAL];
	endproperty
	a_fatal_two: assert property (p_fatal_two) else $error("Loop 2 fatal bit missing");

	property p_fatal_quiet;
		@(posedge clk) disable iff (sys_rst)
		!s.wdt_err && !cjc_q[0] |-> !live_word[0][`LSFW_BIT_FATAL];
	endproperty
	a_fatal_quiet: assert property (p_fatal_quiet) else $error("Fatal bit set with no fault");

	property p_standby_bit;
		@(posedge clk) disable iff (sys_rst)
		live_word[0][`LSFW_BIT_STANDBY] == s.standby && live_word[1][`LSFW_BIT_STANDBY] == s.standby;
	endproperty
	a_standby_bit: assert property (p_standby_bit) else $error("Standby bit does not follow standby");

	property p_restart;
		@(posedge clk) disable iff (sys_rst)
		unit_restart |=> s.standby && !wdt_error;
	endproperty
	a_restart: assert property (p_restart) else $error("Restart did not re-enter standby");

	property p_live_bits_two;
		@(posedge clk) disable iff (sys_rst)
		live_word[0][`LSFW_BIT_SETERR] == setting_invalid[0] && live_word[0][`LSFW_BIT_STOP] == control_stopped[0]
		&& live_word[1][`LSFW_BIT_CTRLOUT] == ctrl_out[1] && live_word[1][`LSFW_BIT_AT] == autotune_running[1];
	endproperty
	a_live_bits_two: assert property (p_live_bits_two) else $error("Live status bit mismatch");

	property p_alarm_two;
		@(posedge clk) disable iff (sys_rst)
		!(absent_q[1] || open_q[1]) && $signed(pv[1]) >= $signed(al2_lo[1]) && $signed(pv[1]) <= $signed(al2_hi[1])
		&& $signed(pv[1]) >= $signed(range_lo[1]) && $signed(pv[1]) <= $signed(range_hi[1])
		|-> live_word[1][`LSFW_BIT_AL2];
	endproperty
	a_alarm_two: assert property (p_alarm_two) else $error("Alarm two not flagged in range");

	property p_alarm_off;
		@(posedge clk) disable iff (sys_rst)
		$signed(pv[0]) < $signed(al1_lo[0]) || $signed(pv[0]) > $signed(al1_hi[0]) |-> !live_word[0][`LSFW_BIT_AL1];
	endproperty
	a_alarm_off: assert property (p_alarm_off) else $error("Alarm one set outside range");

	property p_read_one;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr == `LSFW_OFS_LOOP1 && !io_refresh |=> rd_valid && rd_data == loop1_status_word;
	endproperty
	a_read_one: assert property (p_read_one) else $error("Loop 1 read wrong");

	property p_read_unmapped;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr != `LSFW_OFS_LOOP1 && rd_addr != `LSFW_OFS_LOOP2 |=> rd_data == `LSFW_RESET_WORD;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("Unmapped read not zero");

	property p_start_cause;
		@(posedge clk) disable iff (sys_rst)
		save_start[0] |-> $past(save_word[`LSFW_SAVE_BIT_LOOP1]);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("Loop 1 save started without request");

	property p_wdt_idle;
		@(posedge clk) disable iff (sys_rst)
		io_refresh || s.standby |=> s.wdt_cnt == 32'h0;
	endproperty
	a_wdt_idle: assert property (p_wdt_idle) else $error("Watchdog counted while refreshed");

endmodule // lsfw_status_word

// *** verif/lsfw_copy_model.sv ***
`timescale 1ns/100ps

module lsfw_copy_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [1:0] save_start,
	input wire logic [7:0] delay,
	output logic [1:0] save_done
);
	logic [1:0][7:0] cnt;
	logic [1:0] busy;

	// Each loop's copy finishes delay+1 cycles after its start pulse; a new start restarts the count
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			save_done[i] <= 1'b0;
			if (sys_rst) begin
				busy[i] <= 1'b0;
				cnt[i] <= 8'h00;
			end else if (save_start[i]) begin
				busy[i] <= 1'b1;
				cnt[i] <= delay;
			end else if (busy[i]) begin
				if (cnt[i] == 8'h00) begin
					save_done[i] <= 1'b1;
					busy[i] <= 1'b0;
				end else begin
					cnt[i] <= cnt[i] - 8'h01;
				end
			end
		end
	end
endmodule // lsfw_copy_model

// *** verif/lsfw_status_word_bench.sv ***
`timescale 1ns/100ps
`include "lsfw_params.svh"

module lsfw_status_word_bench;
	localparam int WDT = 64;
	logic clk = 1'b0;
	logic sys_rst, io_refresh, unit_restart, rd_en, rd_valid, wdt_error;
	logic [1:0] sensor_absent, sensor_open, cjc_fault, tuned_update, pid_sent, setting_invalid;
	logic [1:0] control_stopped, ctrl_out, autotune_running, save_done, save_start, sv;
	logic [1:0][15:0] pv, range_lo, range_hi, al1_lo, al1_hi, al2_lo, al2_hi;
	logic [15:0] save_word, rd_data, loop1_status_word, loop2_status_word, e, d;
	logic [3:0] rd_addr;
	logic [7:0] delay;
	int error_cnt = 0;
	int tests_run = 0;
	int bits [10] = '{`LSFW_BIT_SENSOR, `LSFW_BIT_SENSOR, `LSFW_BIT_SENSOR, `LSFW_BIT_FATAL, `LSFW_BIT_SETERR,
		`LSFW_BIT_STOP, `LSFW_BIT_CTRLOUT, `LSFW_BIT_AT, `LSFW_BIT_AL1, `LSFW_BIT_AL2};

	always #25 clk = ~clk;

	lsfw_status_word #(.WDT_CYCLES(WDT)) i_lsfw_status_word (
		.clk(clk), .sys_rst(sys_rst), .io_refresh(io_refresh), .unit_restart(unit_restart),
		.sensor_absent(sensor_absent), .sensor_open(sensor_open), .cjc_fault(cjc_fault), .pv(pv),
		.range_lo(range_lo), .range_hi(range_hi), .al1_lo(al1_lo), .al1_hi(al1_hi), .al2_lo(al2_lo),
		.al2_hi(al2_hi), .tuned_update(tuned_update), .pid_sent(pid_sent), .setting_invalid(setting_invalid),
		.control_stopped(control_stopped), .ctrl_out(ctrl_out), .autotune_running(autotune_running),
		.save_word(save_word), .save_done(save_done), .save_start(save_start), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .loop1_status_word(loop1_status_word),
		.loop2_status_word(loop2_status_word), .wdt_error(wdt_error));

	lsfw_copy_model i_lsfw_copy_model (.clk(clk), .sys_rst(sys_rst), .save_start(save_start), .delay(delay),
		.save_done(save_done));

	task test_done;
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task tmo(input string name);
		chk(name, 16'h0000, 16'h0001);
		test_done;
	endtask

	task cyc(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask

	task refresh;
		io_refresh = 1'b1;
		cyc(1);
		io_refresh = 1'b0;
	endtask

	task rd(input logic [3:0] a, output logic [15:0] q);
		rd_en = 1'b1;
		rd_addr = a;
		cyc(1);
		rd_en = 1'b0;
		for (int i = 0; i < 4 && rd_valid !== 1'b1; i++)
			cyc(1);
		if (rd_valid !== 1'b1)
			tmo("rd_valid");
		q = rd_data;
		cyc(1);
	endtask

	// Refresh, then compare both snapshot ports and both read-back words
	task both(input logic [15:0] e1, input logic [15:0] e2);
		logic [15:0] q;
		refresh;
		chk("loop1_status_word", loop1_status_word, e1);
		chk("loop2_status_word", loop2_status_word, e2);
		rd(`LSFW_OFS_LOOP1, q);
		chk("rd_data loop1", q, e1);
		rd(`LSFW_OFS_LOOP2, q);
		chk("rd_data loop2", q, e2);
	endtask

	task set_case(input int l, input int k, input logic v);
		case (k)
			0: sensor_absent[l] = v;
			1: sensor_open[l] = v;
			2: pv[l] = v ? 16'h07d0 : 16'h0064;
			3: cjc_fault[l] = v;
			4: setting_invalid[l] = v;
			5: control_stopped[l] = v;
			6: ctrl_out[l] = v;
			7: autotune_running[l] = v;
			8: al1_lo[l] = v ? 16'h0000 : 16'h01f4;
			default: al2_lo[l] = v ? 16'h0000 : 16'h01f4;
		endcase
	endtask

	// Loop l requests a save with bit 15-l, the copy model answers dl+1 cycles after the start pulse
	task save(input int l, input logic [7:0] dl);
		delay = dl;
		save_word[15 - l] = 1'b1;
		cyc(1);
		chk("save_start", {14'h0000, save_start}, l ? 16'h0002 : 16'h0001);
		sv[l] = 1'b0;
		if (dl > 8'h04)
			both({sv[0], 15'h0000}, {sv[1], 15'h0000});
		for (int i = 0; i < 20 && save_done[l] !== 1'b1; i++)
			cyc(1);
		if (save_done[l] !== 1'b1)
			tmo("save_done");
		cyc(1);
		sv[l] = 1'b1;
		both({sv[0], 15'h0000}, {sv[1], 15'h0000});
		save_word[15 - l] = 1'b0;
		cyc(1);
	endtask

	initial begin
		sys_rst = 1'b1;
		{io_refresh, unit_restart, rd_en, rd_addr, save_word, delay, sv} = '0;
		{sensor_absent, sensor_open, cjc_fault, tuned_update, pid_sent} = '0;
		{setting_invalid, control_stopped, ctrl_out, autotune_running} = '0;
		for (int l = 0; l < 2; l++) begin
			pv[l] = 16'h0064;
			range_lo[l] = 16'h0000;
			range_hi[l] = 16'h03e8;
			{al1_lo[l], al2_lo[l]} = {16'h01f4, 16'h01f4};
			{al1_hi[l], al2_hi[l]} = {16'h0258, 16'h0258};
		end
		cyc(3);
		sys_rst = 1'b0;
		chk("loop1_status_word reset", loop1_status_word, 16'h0000);
		both(16'h0800, 16'h0800);
		both(16'h0000, 16'h0000);
		rd(4'h3, d);
		chk("rd_data unmapped", d, 16'h0000);
		for (int l = 0; l < 2; l++) begin
			for (int k = 0; k < 10; k++) begin
				set_case(l, k, 1'b1);
				cyc(3);
				e = 16'h0001 << bits[k];
				both(l ? 16'h0000 : e, l ? e : 16'h0000);
				set_case(l, k, 1'b0);
				cyc(3);
				rd(l ? `LSFW_OFS_LOOP2 : `LSFW_OFS_LOOP1, d);
				chk("rd_data held", d, e);
				both(16'h0000, 16'h0000);
			end
		end
		tuned_update[0] = 1'b1;
		cyc(1);
		tuned_update[0] = 1'b0;
		cyc(1);
		both(16'h0400, 16'h0000);
		both(16'h0400, 16'h0000);
		pid_sent[0] = 1'b1;
		cyc(1);
		pid_sent[0] = 1'b0;
		cyc(1);
		both(16'h0000, 16'h0000);
		{tuned_update[1], pid_sent[1]} = 2'h3;
		cyc(1);
		{tuned_update[1], pid_sent[1]} = 2'h0;
		cyc(1);
		both(16'h0000, 16'h0400);
		pid_sent[1] = 1'b1;
		cyc(1);
		pid_sent[1] = 1'b0;
		cyc(1);
		both(16'h0000, 16'h0000);
		save(0, 8'h00);
		save(1, 8'h00);
		save(1, 8'h08);
		save(0, 8'h08);
		for (int i = 0; i < WDT + 40 && wdt_error !== 1'b1; i++)
			cyc(1);
		if (wdt_error !== 1'b1)
			tmo("wdt_error");
		both({sv[0], 15'h1000}, {sv[1], 15'h1000});
		unit_restart = 1'b1;
		cyc(1);
		unit_restart = 1'b0;
		cyc(1);
		chk("wdt_error", {15'h0000, wdt_error}, 16'h0000);
		refresh;
		chk("loop1 standby", loop1_status_word & 16'h1800, 16'h0800);
		chk("loop2 standby", loop2_status_word & 16'h1800, 16'h0800);
		test_done;
	end
endmodule // lsfw_status_word_bench
